/* File: hw/rtu_io_status_regs.sv */
// IO status register bank with uptime, motion timers, momentary supervision and ADC holding
`timescale 1ns/100ps
module rtu_io_status_regs
    import rtu_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Register request port
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [15:0] req_addr_in,
    input wire logic [15:0] req_wdata_in,
    output logic rsp_valid_out,
    output logic rsp_exception_out,
    output logic [7:0] rsp_exc_code_out,
    output logic [31:0] rsp_data_out,
    // Terminal configuration from the IO setup logic
    input wire logic [15:0] din_mask_in,
    input wire logic [15:0] dout_mask_in,
    input wire logic [15:0] open_drain_mask_in,
    input wire logic [15:0] switched_dc_output_in,
    input wire logic [15:0] dual_pin_solenoid_in,
    input wire logic [15:0] three_pin_solenoid_in,
    input wire logic [31:0] pulled_up_input_in,
    // Accelerometer results
    input wire logic [15:0] accel_x_in,
    input wire logic [15:0] accel_y_in,
    input wire logic [15:0] accel_z_in,
    input wire logic [15:0] motion_value_in,
    input wire logic motion_in,
    // Momentary supervision
    input wire logic [15:0] pulse_mask_in,
    input wire logic [15:0] pulse_limit_s_in,
    input wire logic [15:0] output_state_in,
    output logic [15:0] pulse_clear_out,
    // ADC results
    input wire logic adc_raw_wr_in,
    input wire logic [3:0] adc_raw_chan_in,
    input wire logic [15:0] adc_raw_data_in,
    input wire logic adc_precise_wr_in,
    input wire logic [3:0] adc_precise_chan_in,
    input wire logic [31:0] adc_precise_data_in,
    input wire logic [15:0] temperature_in,
    // Text output stream
    output logic text_valid_out,
    output logic [15:0] text_data_out
);

    // Whole state of the block
    typedef struct packed {
        logic [14:0] div_ms;
        logic [9:0] ms_in_sec;
        logic [7:0] up_sec;
        logic [7:0] up_min;
        logic [7:0] up_hour;
        logic [7:0] up_day;
        logic [31:0] still_ms;
        logic [31:0] moving_ms;
        logic [15:0][15:0] on_secs;
        logic [15:0] pulse_count;
        logic [15:0][15:0] adc_raw;
        logic [15:0][31:0] adc_precise;
        logic rsp_valid;
        logic rsp_exc;
        logic [7:0] rsp_code;
        logic [31:0] rsp_data;
        logic text_valid;
        logic [15:0] text_data;
        logic [15:0] pulse_clear;
    } rtu_state_t;

    rtu_state_t st_reg; // Registered state
    rtu_state_t st_next; // Next state
    logic ms_tick; // One-cycle millisecond enable
    logic sec_tick; // One-cycle second enable
    logic rd_hit; // Address names a readable register
    logic [31:0] rd_data; // Read value for the address
    logic [15:0] raw_off; // Offset into raw ADC group
    logic [15:0] precise_off; // Offset into precise ADC group

    // Last divider count, cut to the divider width
    localparam logic [14:0] DIV_LAST = 15'(TICK_CYCLES_P - 1);

    // Number of set bits in a 16-bit word
    function automatic logic [4:0] rtu_popcount(input logic [15:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 16; i++)
        begin
            n = n + {4'h0, v[i]};
        end
        return n;
    endfunction : rtu_popcount

    // Tick enables from the divider
    assign ms_tick = (st_reg.div_ms == DIV_LAST);
    assign sec_tick = ms_tick && (st_reg.ms_in_sec == MS_PER_SEC_LAST);
    assign raw_off = req_addr_in - ADC_RAW_BASE;
    assign precise_off = req_addr_in - ADC_PRECISE_BASE;

    // Read decode
    always_comb
    begin
        rd_hit = 1'b1;
        rd_data = ZERO32;
        if (raw_off < ADC_CHANNELS)
        begin
            rd_data = {16'h0000, st_reg.adc_raw[raw_off[3:0]]};
        end
        else if (precise_off < ADC_CHANNELS)
        begin
            rd_data = st_reg.adc_precise[precise_off[3:0]];
        end
        else
        begin
            unique case (req_addr_in)
                DIN_MASK_ADDR: rd_data = {16'h0000, din_mask_in};
                DOUT_MASK_ADDR: rd_data = {16'h0000, dout_mask_in};
                OPEN_DRAIN_ADDR: rd_data = {16'h0000, open_drain_mask_in};
                SWITCHED_ADDR: rd_data = {16'h0000, switched_dc_output_in};
                DUAL_SOL_ADDR: rd_data = {16'h0000, dual_pin_solenoid_in};
                TRIPLE_SOL_ADDR: rd_data = {16'h0000, three_pin_solenoid_in};
                PULLUP_ADDR: rd_data = pulled_up_input_in;
                UPTIME_ADDR: rd_data = {st_reg.up_day, st_reg.up_hour, st_reg.up_min, st_reg.up_sec};
                ACCEL_X_ADDR: rd_data = {16'h0000, accel_x_in};
                ACCEL_Y_ADDR: rd_data = {16'h0000, accel_y_in};
                ACCEL_Z_ADDR: rd_data = {16'h0000, accel_z_in};
                MOTION_VAL_ADDR: rd_data = {16'h0000, motion_value_in};
                MOTION_FLAG_ADDR: rd_data = {31'h00000000, motion_in};
                STILL_MS_ADDR: rd_data = st_reg.still_ms;
                MOVING_MS_ADDR: rd_data = st_reg.moving_ms;
                PULSE_MASK_ADDR: rd_data = {16'h0000, pulse_mask_in};
                PULSE_LIMIT_ADDR: rd_data = {16'h0000, pulse_limit_s_in};
                PULSE_COUNT_ADDR: rd_data = {16'h0000, st_reg.pulse_count};
                TEMPERATURE_ADDR: rd_data = {16'h0000, temperature_in};
                default: rd_hit = 1'b0;
            endcase
        end
    end

    // Next-state logic
    always_comb
    begin
        st_next = st_reg;
        st_next.rsp_valid = 1'b0;
        st_next.text_valid = 1'b0;
        st_next.pulse_clear = 16'h0000;
        // Millisecond divider and second prescaler
        st_next.div_ms = ms_tick ? 15'h0000 : st_reg.div_ms + 15'h0001;
        if (ms_tick)
        begin
            st_next.ms_in_sec = sec_tick ? 10'h000 : st_reg.ms_in_sec + 10'h001;
        end
        // Uptime carry chain; days wrap after 255
        if (sec_tick)
        begin
            if (st_reg.up_sec != SEC_LAST)
            begin
                st_next.up_sec = st_reg.up_sec + 8'h01;
            end
            else
            begin
                st_next.up_sec = 8'h00;
                if (st_reg.up_min != MIN_LAST)
                begin
                    st_next.up_min = st_reg.up_min + 8'h01;
                end
                else
                begin
                    st_next.up_min = 8'h00;
                    if (st_reg.up_hour != HOUR_LAST)
                    begin
                        st_next.up_hour = st_reg.up_hour + 8'h01;
                    end
                    else
                    begin
                        st_next.up_hour = 8'h00;
                        st_next.up_day = st_reg.up_day + 8'h01;
                    end
                end
            end
        end
        // Motion timers restart on each change and saturate
        if (motion_in)
        begin
            st_next.still_ms = ZERO32;
            if (ms_tick && st_reg.moving_ms != SAT32)
            begin
                st_next.moving_ms = st_reg.moving_ms + 32'h00000001;
            end
        end
        else
        begin
            st_next.moving_ms = ZERO32;
            if (ms_tick && st_reg.still_ms != SAT32)
            begin
                st_next.still_ms = st_reg.still_ms + 32'h00000001;
            end
        end

        // Momentary supervision per terminal; a zero limit disables it
        for (int i = 0; i < 16; i++)
        begin
            if (pulse_mask_in[i] && output_state_in[i] && !st_reg.pulse_clear[i])
            begin
                if (pulse_limit_s_in != 16'h0000 && st_reg.on_secs[i] >= pulse_limit_s_in)
                begin
                    st_next.pulse_clear[i] = 1'b1;
                    st_next.on_secs[i] = 16'h0000;
                end
                else if (sec_tick && st_reg.on_secs[i] != SAT16)
                begin
                    st_next.on_secs[i] = st_reg.on_secs[i] + 16'h0001;
                end
            end
            else
            begin
                st_next.on_secs[i] = 16'h0000;
            end
        end

        // Each forced bit adds one
        st_next.pulse_count = st_reg.pulse_count + {11'h000, rtu_popcount(st_next.pulse_clear)};

        // Capture of ADC results
        if (adc_raw_wr_in)
        begin
            st_next.adc_raw[adc_raw_chan_in] = adc_raw_data_in;
        end
        if (adc_precise_wr_in)
        begin
            st_next.adc_precise[adc_precise_chan_in] = adc_precise_data_in;
        end

        // Register request handling, answered one cycle later
        if (req_valid_in)
        begin
            st_next.rsp_valid = 1'b1;
            st_next.rsp_exc = 1'b0;
            st_next.rsp_code = EXC_NONE;
            st_next.rsp_data = ZERO32;
            if (req_addr_in == TEXT_OUT_ADDR)
            begin
                if (req_write_in)
                begin
                    st_next.text_valid = 1'b1;
                    st_next.text_data = req_wdata_in;
                end
                else
                begin
                    st_next.rsp_exc = 1'b1;
                    st_next.rsp_code = EXC_ILLEGAL_FUNC;
                end
            end
            else if (!rd_hit)
            begin
                st_next.rsp_exc = 1'b1;
                st_next.rsp_code = EXC_ILLEGAL_ADDR;
            end
            else if (req_write_in)
            begin
                st_next.rsp_exc = 1'b1;
                st_next.rsp_code = EXC_ILLEGAL_FUNC;
            end
            else
            begin
                st_next.rsp_data = rd_data;
            end
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign rsp_valid_out = st_reg.rsp_valid;
    assign rsp_exception_out = st_reg.rsp_exc;
    assign rsp_exc_code_out = st_reg.rsp_code;
    assign rsp_data_out = st_reg.rsp_data;
    assign pulse_clear_out = st_reg.pulse_clear;
    assign text_valid_out = st_reg.text_valid;
    assign text_data_out = st_reg.text_data;

    // Checks
    a_ro_write_exc: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        req_valid_in && req_write_in && req_addr_in == DIN_MASK_ADDR
        |=> rsp_valid_out && rsp_exception_out && rsp_exc_code_out == EXC_ILLEGAL_FUNC && !text_valid_out)
        else $error("write to read-only register not refused");

    a_din_read_data: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        req_valid_in && !req_write_in && req_addr_in == DIN_MASK_ADDR
        |=> !rsp_exception_out && rsp_data_out == {16'h0000, $past(din_mask_in)})
        else $error("input mask read returned wrong data");

    a_pullup_read_data: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        req_valid_in && !req_write_in && req_addr_in == PULLUP_ADDR
        |=> rsp_data_out == $past(pulled_up_input_in))
        else $error("pull-up mask read returned wrong data");

    a_motion_flag_read: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        req_valid_in && !req_write_in && req_addr_in == MOTION_FLAG_ADDR
        |=> rsp_data_out == {31'h00000000, $past(motion_in)})
        else $error("motion flag read wrong");

    a_still_clear_move: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        motion_in |=> st_reg.still_ms == ZERO32)
        else $error("still time not cleared during motion");

    a_moving_clear_still: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !motion_in |=> st_reg.moving_ms == ZERO32)
        else $error("motion time not cleared while still");

    a_uptime_sec_range: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        st_reg.up_sec <= SEC_LAST && st_reg.up_min <= MIN_LAST && st_reg.up_hour <= HOUR_LAST)
        else $error("uptime field out of range");

    a_clear_needs_mask: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (pulse_clear_out & ~$past(pulse_mask_in & output_state_in)) == 16'h0000)
        else $error("forced clear on unsupervised output");

    a_reset_count_step: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        $past(rst_b_in) |-> st_reg.pulse_count == $past(st_reg.pulse_count) + {11'h000, rtu_popcount(pulse_clear_out)})
        else $error("reset counter step wrong");

    a_adc_raw_hold: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        adc_raw_wr_in |=> st_reg.adc_raw[$past(adc_raw_chan_in)] == $past(adc_raw_data_in))
        else $error("raw ADC result not held");

    a_text_write_out: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        req_valid_in && req_write_in && req_addr_in == TEXT_OUT_ADDR
        |=> text_valid_out && text_data_out == $past(req_wdata_in) && !rsp_exception_out ##1 (!text_valid_out || $past(req_valid_in)))
        else $error("text write not forwarded");

    a_text_read_refused: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        req_valid_in && !req_write_in && req_addr_in == TEXT_OUT_ADDR
        |=> rsp_valid_out && rsp_exception_out && rsp_exc_code_out == EXC_ILLEGAL_FUNC)
        else $error("read of text register not refused");

    a_adc_precise_hold: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        adc_precise_wr_in |=> st_reg.adc_precise[$past(adc_precise_chan_in)] == $past(adc_precise_data_in))
        else $error("precise ADC result not held");

endmodule : rtu_io_status_regs

/* File: hw/rtu_pkg.sv */
// Register map, response codes and timing constants of the IO status register bank
package rtu_pkg;
    // Register addresses
    localparam logic [15:0] DIN_MASK_ADDR = 16'h138C;
    localparam logic [15:0] DOUT_MASK_ADDR = 16'h138D;
    localparam logic [15:0] OPEN_DRAIN_ADDR = 16'h138E;
    localparam logic [15:0] SWITCHED_ADDR = 16'h138F;
    localparam logic [15:0] DUAL_SOL_ADDR = 16'h1393;
    localparam logic [15:0] TRIPLE_SOL_ADDR = 16'h1394;
    localparam logic [15:0] PULLUP_ADDR = 16'h1395;
    localparam logic [15:0] UPTIME_ADDR = 16'h13A6;
    localparam logic [15:0] ACCEL_X_ADDR = 16'h1450;
    localparam logic [15:0] ACCEL_Y_ADDR = 16'h1451;
    localparam logic [15:0] ACCEL_Z_ADDR = 16'h1452;
    localparam logic [15:0] MOTION_VAL_ADDR = 16'h1453;
    localparam logic [15:0] MOTION_FLAG_ADDR = 16'h1454;
    localparam logic [15:0] STILL_MS_ADDR = 16'h1455;
    localparam logic [15:0] MOVING_MS_ADDR = 16'h1456;
    localparam logic [15:0] PULSE_MASK_ADDR = 16'h1482;
    localparam logic [15:0] PULSE_LIMIT_ADDR = 16'h1483;
    localparam logic [15:0] PULSE_COUNT_ADDR = 16'h1484;
    localparam logic [15:0] ADC_RAW_BASE = 16'h1770;
    localparam logic [15:0] ADC_PRECISE_BASE = 16'h1798;
    localparam logic [15:0] TEMPERATURE_ADDR = 16'h17AC;
    localparam logic [15:0] TEXT_OUT_ADDR = 16'h17D4;
    // Channels per ADC register group
    localparam logic [15:0] ADC_CHANNELS = 16'h0010;
    // Exception codes
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
    // Uptime field limits
    localparam logic [7:0] SEC_LAST = 8'h3B;
    localparam logic [7:0] MIN_LAST = 8'h3B;
    localparam logic [7:0] HOUR_LAST = 8'h17;
    localparam logic [9:0] MS_PER_SEC_LAST = 10'h3E7;
    // Timing
    localparam int CLOCK_HZ = 25000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
    // Zero and saturation values
    localparam logic [31:0] ZERO32 = 32'h00000000;
    localparam logic [31:0] SAT32 = 32'hFFFFFFFF;
    localparam logic [15:0] SAT16 = 16'hFFFF;
endpackage : rtu_pkg

/* File: verification/rtu_master_model.sv */
// Polling master model that issues one register request at a time
`timescale 1ns/100ps
module rtu_master_model
    import rtu_pkg::*;
(
    input wire logic clock_in,
    output logic req_valid_out,
    output logic req_write_out,
    output logic [15:0] req_addr_out,
    output logic [15:0] req_wdata_out,
    input wire logic rsp_valid_in,
    input wire logic [7:0] rsp_exc_code_in,
    input wire logic [31:0] rsp_data_in
);
    int text_bytes = 0; // Bytes sent so far in the current text message
    // Idle bus at time zero
    initial
    begin
        req_valid_out = 1'b0;
        req_write_out = 1'b0;
        req_addr_out = 16'h0000;
        req_wdata_out = 16'h0000;
    end
    // One request: strobe for one cycle, then wait a bounded time for the answer
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
                          output logic [31:0] q, output logic [7:0] code, output logic ok);
        int n;
        ok = 1'b0;
        q = 32'h00000000;
        code = 8'hFF;
        // Start a new message rather than exceed the text byte limit
        if (wr && a == TEXT_OUT_ADDR)
        begin
            text_bytes = (text_bytes + 2 > 246) ? 2 : text_bytes + 2;
        end
        @(negedge clock_in);
        req_valid_out = 1'b1;
        req_write_out = wr;
        req_addr_out = a;
        req_wdata_out = d;
        // Taken at the next rising edge; the answer stands for the cycle after it
        for (n = 0; n < 8 && !ok; n++)
        begin
            @(negedge clock_in);
            // Released lines show a changed value, not the last one
            req_valid_out = 1'b0;
            req_addr_out = ~a;
            req_wdata_out = ~d;
            if (rsp_valid_in === 1'b1)
            begin
                ok = 1'b1;
                q = rsp_data_in;
                code = rsp_exc_code_in;
            end
        end
    endtask : access
endmodule : rtu_master_model

/* File: verification/test_rtu_io_status_regs.sv */
// Self-checking testbench of the IO status register bank
`timescale 1ns/100ps
module test_rtu_io_status_regs;
    import rtu_pkg::*;
    localparam int TICK_P = 4; // Shortened cycles per millisecond
    localparam int SEC_CYC = TICK_P * 1000; // Cycles per second at that rate
    logic clock_in, rst_b_in, req_valid_in, req_write_in, rsp_valid_out, rsp_exception_out;
    logic [15:0] req_addr_in, req_wdata_in;
    logic [7:0] rsp_exc_code_out;
    logic [31:0] rsp_data_out, pulled_up_input_in, adc_precise_data_in;
    logic [15:0] din_mask_in, dout_mask_in, open_drain_mask_in, switched_dc_output_in;
    logic [15:0] dual_pin_solenoid_in, three_pin_solenoid_in, accel_x_in, accel_y_in, accel_z_in;
    logic [15:0] motion_value_in, pulse_mask_in, pulse_limit_s_in, output_state_in, pulse_clear_out;
    logic [15:0] adc_raw_data_in, temperature_in, text_data_out, clr_seen;
    logic motion_in, adc_raw_wr_in, adc_precise_wr_in, text_valid_out, ok;
    logic [3:0] adc_raw_chan_in, adc_precise_chan_in;
    logic [31:0] q, q2;
    logic [7:0] code;
    logic [15:0] raw_exp [16];
    logic [31:0] prec_exp [16];
    int error_cnt = 0, check_count = 0, clr_total = 0, seed = 61, i, r;
    // Registers read live, one table for every round
    localparam logic [15:0] LIVE [15] = '{DIN_MASK_ADDR, DOUT_MASK_ADDR, OPEN_DRAIN_ADDR, SWITCHED_ADDR,
        DUAL_SOL_ADDR, TRIPLE_SOL_ADDR, PULLUP_ADDR, ACCEL_X_ADDR, ACCEL_Y_ADDR, ACCEL_Z_ADDR,
        MOTION_VAL_ADDR, MOTION_FLAG_ADDR, PULSE_MASK_ADDR, PULSE_LIMIT_ADDR, TEMPERATURE_ADDR};

    rtu_io_status_regs #(.TICK_CYCLES_P(TICK_P)) uut (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
        .req_wdata_in(req_wdata_in), .rsp_valid_out(rsp_valid_out), .rsp_exception_out(rsp_exception_out),
        .rsp_exc_code_out(rsp_exc_code_out), .rsp_data_out(rsp_data_out), .din_mask_in(din_mask_in),
        .dout_mask_in(dout_mask_in), .open_drain_mask_in(open_drain_mask_in),
        .switched_dc_output_in(switched_dc_output_in), .dual_pin_solenoid_in(dual_pin_solenoid_in),
        .three_pin_solenoid_in(three_pin_solenoid_in), .pulled_up_input_in(pulled_up_input_in),
        .accel_x_in(accel_x_in), .accel_y_in(accel_y_in), .accel_z_in(accel_z_in),
        .motion_value_in(motion_value_in), .motion_in(motion_in), .pulse_mask_in(pulse_mask_in),
        .pulse_limit_s_in(pulse_limit_s_in), .output_state_in(output_state_in),
        .pulse_clear_out(pulse_clear_out), .adc_raw_wr_in(adc_raw_wr_in), .adc_raw_chan_in(adc_raw_chan_in),
        .adc_raw_data_in(adc_raw_data_in), .adc_precise_wr_in(adc_precise_wr_in),
        .adc_precise_chan_in(adc_precise_chan_in), .adc_precise_data_in(adc_precise_data_in),
        .temperature_in(temperature_in), .text_valid_out(text_valid_out), .text_data_out(text_data_out));

    rtu_master_model master (.clock_in(clock_in), .req_valid_out(req_valid_in), .req_write_out(req_write_in),
        .req_addr_out(req_addr_in), .req_wdata_out(req_wdata_in), .rsp_valid_in(rsp_valid_out),
        .rsp_exc_code_in(rsp_exc_code_out), .rsp_data_in(rsp_data_out));

    // Clock at 25 MHz
    initial
    begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    // Output driver answers a forced clear by dropping that output, and counts clears
    always @(negedge clock_in)
    begin
        if (pulse_clear_out !== 16'h0000)
        begin
            output_state_in <= output_state_in & ~pulse_clear_out;
            clr_seen <= clr_seen | pulse_clear_out;
            clr_total <= clr_total + $countones(pulse_clear_out);
        end
    end
    // Expected value of a live register from the present inputs
    function automatic logic [31:0] expect_reg(input logic [15:0] a);
        case (a)
            DIN_MASK_ADDR: return {16'h0000, din_mask_in};
            DOUT_MASK_ADDR: return {16'h0000, dout_mask_in};
            OPEN_DRAIN_ADDR: return {16'h0000, open_drain_mask_in};
            SWITCHED_ADDR: return {16'h0000, switched_dc_output_in};
            DUAL_SOL_ADDR: return {16'h0000, dual_pin_solenoid_in};
            TRIPLE_SOL_ADDR: return {16'h0000, three_pin_solenoid_in};
            PULLUP_ADDR: return pulled_up_input_in;
            ACCEL_X_ADDR: return {16'h0000, accel_x_in};
            ACCEL_Y_ADDR: return {16'h0000, accel_y_in};
            ACCEL_Z_ADDR: return {16'h0000, accel_z_in};
            MOTION_VAL_ADDR: return {16'h0000, motion_value_in};
            MOTION_FLAG_ADDR: return {31'h00000000, motion_in};
            PULSE_MASK_ADDR: return {16'h0000, pulse_mask_in};
            PULSE_LIMIT_ADDR: return {16'h0000, pulse_limit_s_in};
            default: return {16'h0000, temperature_in};
        endcase
    endfunction : expect_reg
    // Compare one value and count it
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // Print counts and verdict, then stop
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // Bus access with a missing answer treated as a failure
    task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] d);
        master.access(wr, a, d, q, code, ok);
        if (!ok)
        begin
            error_cnt++;
            $display("BAD answer expected 1 seen 0");
            give_verdict();
        end
    endtask : bus
    // Main sequence
    initial
    begin
        rst_b_in = 1'b0;
        {motion_in, adc_raw_wr_in, adc_precise_wr_in, adc_raw_chan_in, adc_precise_chan_in} = '0;
        {din_mask_in, dout_mask_in, open_drain_mask_in, switched_dc_output_in, dual_pin_solenoid_in} = '1;
        {three_pin_solenoid_in, pulled_up_input_in, temperature_in, pulse_mask_in, pulse_limit_s_in} = '1;
        {accel_x_in, accel_y_in, accel_z_in, motion_value_in} = {16'h005A, 16'hFFA6, 16'h0000, 16'hFFFF};
        {output_state_in, clr_seen, adc_raw_data_in, adc_precise_data_in} = '0;
        repeat (5) @(negedge clock_in);
        rst_b_in = 1'b1;
        // Round 0 uses all-ones and range ends, later rounds random values
        for (r = 0; r < 3; r++)
        begin
            for (i = 0; i < 15; i++)
            begin
                bus(1'b0, LIVE[i], 16'h0000);
                check("live", expect_reg(LIVE[i]), q);
                bus(1'b1, LIVE[i], 16'($random(seed)));
                check("ro_write", {23'h000000, 1'b1, EXC_ILLEGAL_FUNC}, {23'h000000, rsp_exception_out, code});
                bus(1'b0, LIVE[i], 16'h0000);
                check("ro_kept", expect_reg(LIVE[i]), q);
            end
            {din_mask_in, dout_mask_in, pulled_up_input_in} = {16'($random(seed)), 16'($random(seed)), $random(seed)};
            {open_drain_mask_in, switched_dc_output_in} = {16'($random(seed)), 16'($random(seed))};
            {dual_pin_solenoid_in, three_pin_solenoid_in} = {16'($random(seed)), 16'($random(seed))};
            {accel_x_in, accel_y_in} = {16'($random(seed) % 91), 16'($random(seed) % 91)};
            {accel_z_in, motion_value_in} = {16'($random(seed) % 91), 16'($random(seed))};
            {temperature_in, pulse_mask_in, pulse_limit_s_in} = {16'($random(seed)), 32'($random(seed))};
            motion_in = 1'($random(seed));
        end
        bus(1'b0, 16'h1390, 16'h0000);
        check("unmapped", {23'h000000, 1'b1, EXC_ILLEGAL_ADDR}, {23'h000000, rsp_exception_out, code});
        bus(1'b0, TEXT_OUT_ADDR, 16'h0000);
        check("text_read", {23'h000000, 1'b1, EXC_ILLEGAL_FUNC}, {23'h000000, rsp_exception_out, code});
        for (i = 0; i < 2; i++)
        begin
            q2 = $random(seed);
            bus(1'b1, TEXT_OUT_ADDR, q2[15:0]);
            q = {6'h00, rsp_exception_out, text_valid_out, code, text_data_out};
            check("text_out", {6'h00, 1'b0, 1'b1, EXC_NONE, q2[15:0]}, q);
        end
        // Store every ADC channel back to back, then read them all
        for (i = 0; i < 16; i++)
        begin
            raw_exp[i] = 16'($random(seed));
            prec_exp[15 - i] = $random(seed);
            {adc_raw_wr_in, adc_precise_wr_in, adc_raw_chan_in, adc_precise_chan_in} = {2'b11, 4'(i), 4'(15 - i)};
            {adc_raw_data_in, adc_precise_data_in} = {raw_exp[i], prec_exp[15 - i]};
            @(negedge clock_in);
        end
        {adc_raw_wr_in, adc_precise_wr_in} = 2'b00;
        for (i = 0; i < 16; i++)
        begin
            bus(1'b0, ADC_RAW_BASE + 16'(i), 16'h0000);
            check("adc_raw", {16'h0000, raw_exp[i]}, q);
            bus(1'b0, ADC_PRECISE_BASE + 16'(i), 16'h0000);
            check("adc_precise", prec_exp[i], q);
        end
        // Motion timers: 40 cycles between taken edges is exactly 10 ticks
        for (r = 0; r < 2; r++)
        begin
            motion_in = r[0] ? 1'b0 : 1'b1;
            repeat (20) @(negedge clock_in);
            bus(1'b0, r[0] ? MOVING_MS_ADDR : STILL_MS_ADDR, 16'h0000);
            check("idle_timer", 32'h00000000, q);
            bus(1'b0, r[0] ? STILL_MS_ADDR : MOVING_MS_ADDR, 16'h0000);
            q2 = q;
            repeat (39) @(posedge clock_in);
            bus(1'b0, r[0] ? STILL_MS_ADDR : MOVING_MS_ADDR, 16'h0000);
            check("ms_timer", q2 + 32'd10, q);
        end
        // Uptime: two seconds between taken edges, upper fields still zero
        bus(1'b0, UPTIME_ADDR, 16'h0000);
        q2 = q;
        repeat (2 * SEC_CYC - 1) @(posedge clock_in);
        bus(1'b0, UPTIME_ADDR, 16'h0000);
        check("uptime", {24'h000000, q2[7:0] + 8'h02}, q);
        // Supervised bits 0 and 2 are cleared, unsupervised bit 1 stays on
        {pulse_mask_in, pulse_limit_s_in, output_state_in} = {16'h0005, 16'h0001, 16'h0007};
        for (i = 0; i < 3 * SEC_CYC && output_state_in !== 16'h0002; i++)
            @(negedge clock_in);
        check("cleared", {16'h0005, 16'h0002}, {clr_seen, output_state_in});
        bus(1'b0, PULSE_COUNT_ADDR, 16'h0000);
        check("reset_count", 32'(clr_total), q);
        check("reset_total", 32'h00000002, 32'(clr_total));
        give_verdict();
    end
endmodule : test_rtu_io_status_regs
